// File: rtl/wave_shutdown_steering.sv
// Purpose: auto-shutdown and output steering of a four-output generator
// Assumes: one 40 MHz clock; all wave and source inputs are asynchronous
// Notes:   bridge and push-pull modes drive the inactive level only
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module wave_shutdown_steering (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic awvalid,
   output logic awready,
   input wire logic [wss_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi4-lite write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi4-lite read
   input wire logic arvalid,
   output logic arready,
   input wire logic [wss_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // waveform and shutdown sources
   input wire logic data_wave,
   input wire wss_pkg::sd_src_t shutdown_sources,
   // output pins with enables
   output logic wave_out_a,
   output logic wave_out_b,
   output logic wave_out_c,
   output logic wave_out_d,
   output logic [3:0] wave_oe,
   // interrupt
   output logic irq
);
   // register state
   wss_pkg::sd_ctl_t as0_q;
   logic [6:0] src_en_q;
   logic [7:0] str_q;
   logic [7:0] ctrl_q;
   logic [3:0] pol_q;
   logic [wss_pkg::DB_W-1:0] dbr_q;
   logic [wss_pkg::DB_W-1:0] dbf_q;
   logic [1:0] ist_q;
   logic [1:0] imsk_q;

   // bus state
   logic aw_hold_q;
   logic w_hold_q;
   logic [wss_pkg::IDX_W-1:0] wr_idx_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;

   // synchronised inputs
   logic [7:0] in_m_q;
   logic [7:0] in_s_q;
   logic data_s;
   logic data_prev_q;
   logic data_rise;
   logic [6:0] src_s;

   // shutdown and output state
   logic shutdown_d;
   logic hold_q;
   logic hold_d;
   logic src_active;
   logic [3:0] steer_act_q;
   logic [3:0] out_q;
   logic [3:0] oe_q;
   logic [1:0] db_busy;
   logic en;
   logic [2:0] mode;
   logic steer_mode;
   logic [3:0][1:0] lvl_of;

   // write strobes
   logic wr_fire;
   logic wr_ok;
   logic as0_wr;
   logic [1:0] ist_ev;

   assign en = ctrl_q[wss_pkg::EN_BIT];
   assign mode = ctrl_q[2:0];
   assign steer_mode = (mode[2:1] == 2'h0);

   // two-flop synchroniser for the data wave and all seven sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_m_q <= 8'h00;
         in_s_q <= 8'h00;
         data_prev_q <= 1'b0;
      end else begin
         in_m_q <= {data_wave, shutdown_sources};
         in_s_q <= in_m_q;
         data_prev_q <= in_s_q[7];
      end
   end

   assign data_s = in_s_q[7];
   assign src_s = in_s_q[6:0];
   assign data_rise = data_s & ~data_prev_q;

   // active-low sources are flipped so every hit is a one
   assign src_active = |((src_s ^ wss_pkg::SRC_ACT_LOW) & src_en_q);

   // write channel: address and data taken in either order
   assign wr_fire = aw_hold_q & w_hold_q & ~bvalid;
   assign wr_ok = wr_fire & wstrb0_q;
   assign as0_wr = wr_ok & (wr_idx_q == wss_pkg::IDX_AS0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         wr_idx_q <= '0;
         wdata_q <= 32'h0000_0000;
         wstrb0_q <= 1'b0;
         bvalid <= 1'b0;
         bresp <= wss_pkg::RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_q <= 1'b1;
            awready <= 1'b0;
            wr_idx_q <= awaddr[wss_pkg::ADDR_W-1:2];
         end
         if (wvalid && wready) begin
            w_hold_q <= 1'b1;
            wready <= 1'b0;
            wdata_q <= wdata;
            wstrb0_q <= wstrb[0];
         end
         if (wr_fire) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= idx_mapped(wr_idx_q) ? wss_pkg::RESP_OKAY
                                          : wss_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // decode of the mapped word indices
   function automatic logic idx_mapped(
      input logic [wss_pkg::IDX_W-1:0] idx);
      idx_mapped = (idx == wss_pkg::IDX_DBR) || (idx == wss_pkg::IDX_DBF)
         || (idx == wss_pkg::IDX_CTRL) || (idx == wss_pkg::IDX_POL)
         || (idx == wss_pkg::IDX_AS0) || (idx == wss_pkg::IDX_AS1)
         || (idx == wss_pkg::IDX_STR) || (idx == wss_pkg::IDX_IST)
         || (idx == wss_pkg::IDX_IMSK);
   endfunction : idx_mapped

   // plain configuration registers; writes accepted whatever the enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_en_q <= wss_pkg::AS1_RST;
         str_q <= wss_pkg::STR_RST;
         ctrl_q <= wss_pkg::CTRL_RST;
         pol_q <= wss_pkg::POL_RST;
         dbr_q <= wss_pkg::DB_RST;
         dbf_q <= wss_pkg::DB_RST;
         imsk_q <= 2'h0;
      end else if (wr_ok) begin
         if (wr_idx_q == wss_pkg::IDX_AS1) begin
            src_en_q <= wdata_q[6:0];
         end else if (wr_idx_q == wss_pkg::IDX_STR) begin
            str_q <= wdata_q[7:0];
         end else if (wr_idx_q == wss_pkg::IDX_CTRL) begin
            ctrl_q <= {wdata_q[7], 4'h0, wdata_q[2:0]};
         end else if (wr_idx_q == wss_pkg::IDX_POL) begin
            pol_q <= wdata_q[3:0];
         end else if (wr_idx_q == wss_pkg::IDX_DBR) begin
            dbr_q <= wdata_q[wss_pkg::DB_W-1:0];
         end else if (wr_idx_q == wss_pkg::IDX_DBF) begin
            dbf_q <= wdata_q[wss_pkg::DB_W-1:0];
         end else if (wr_idx_q == wss_pkg::IDX_IMSK) begin
            imsk_q <= wdata_q[1:0];
         end
      end
   end

   // shutdown flag: a live source always wins over a software clear
   always_comb begin
      if (src_active) begin
         shutdown_d = 1'b1;
      end else if (as0_wr) begin
         shutdown_d = wdata_q[7];
      end else if (as0_q.restart_en) begin
         shutdown_d = 1'b0;
      end else begin
         shutdown_d = as0_q.shutdown;
      end
   end

   // outputs leave shutdown only on a data rising edge after the clear
   assign hold_d = shutdown_d | (hold_q & ~data_rise);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         as0_q <= wss_pkg::AS0_RST;
         hold_q <= 1'b0;
      end else begin
         as0_q.shutdown <= shutdown_d;
         hold_q <= hold_d;
         if (as0_wr) begin
            as0_q.restart_en <= wdata_q[6];
            as0_q.pair_bd_shutdown_level <= wdata_q[5:4];
            as0_q.pair_ac_shutdown_level <= wdata_q[3:2];
         end
      end
   end

   // one dead-band timer per pair, started as shutdown takes hold
   dead_band_timer u_db_ac (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(hold_d & ~hold_q),
      .count(dbf_q),
      .busy(db_busy[0])
   );

   dead_band_timer u_db_bd (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(hold_d & ~hold_q),
      .count(dbr_q),
      .busy(db_busy[1])
   );

   // steering enables: direct in async mode, reloaded per data edge in
   // sync mode so a change never cuts a pulse short
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         steer_act_q <= 4'h0;
      end else if (mode != wss_pkg::MODE_SYNC) begin
         steer_act_q <= str_q[3:0];
      end else if (data_rise) begin
         steer_act_q <= str_q[3:0];
      end
   end

   // shutdown code per output: a and c share one code, b and d the other
   assign lvl_of = {as0_q.pair_bd_shutdown_level,
                    as0_q.pair_ac_shutdown_level,
                    as0_q.pair_bd_shutdown_level,
                    as0_q.pair_ac_shutdown_level};

   // output stage: shutdown first, then disable, then steering
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_q <= 4'h0;
         oe_q <= 4'hF;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hold_q) begin
               if (lvl_of[i] == wss_pkg::LVL_HIGH) begin
                  out_q[i] <= 1'b1;
                  oe_q[i] <= 1'b1;
               end else if (lvl_of[i] == wss_pkg::LVL_LOW) begin
                  out_q[i] <= 1'b0;
                  oe_q[i] <= 1'b1;
               end else if (lvl_of[i] == wss_pkg::LVL_HIZ) begin
                  oe_q[i] <= 1'b0;
               end else if (!db_busy[i%2]) begin
                  out_q[i] <= pol_q[i];
                  oe_q[i] <= 1'b1;
               end
            end else if (!en) begin
               out_q[i] <= pol_q[i];
               oe_q[i] <= 1'b1;
            end else if (steer_mode) begin
               oe_q[i] <= 1'b1;
               if (steer_act_q[i]) begin
                  out_q[i] <= data_s ^ pol_q[i];
               end else begin
                  out_q[i] <= str_q[4+i];
               end
            end else begin
               out_q[i] <= pol_q[i];
               oe_q[i] <= 1'b1;
            end
         end
      end
   end

   assign wave_out_a = out_q[0];
   assign wave_out_b = out_q[1];
   assign wave_out_c = out_q[2];
   assign wave_out_d = out_q[3];
   assign wave_oe = oe_q;

   // interrupt: shutdown entry and resume events, write one to clear
   assign ist_ev[wss_pkg::IRQ_ENTER] = hold_d & ~hold_q;
   assign ist_ev[wss_pkg::IRQ_RESUME] = ~hold_d & hold_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ist_q <= 2'h0;
         irq <= 1'b0;
      end else begin
         if (wr_ok && (wr_idx_q == wss_pkg::IDX_IST)) begin
            ist_q <= (ist_q & ~wdata_q[1:0]) | ist_ev;
         end else begin
            ist_q <= ist_q | ist_ev;
         end
         irq <= |(ist_q & imsk_q);
      end
   end

   // read channel: one word per request, data registered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= wss_pkg::RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= idx_mapped(araddr[wss_pkg::ADDR_W-1:2])
                  ? wss_pkg::RESP_OKAY : wss_pkg::RESP_SLVERR;
         rdata <= {24'h00_0000, rd_byte(araddr[wss_pkg::ADDR_W-1:2])};
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // read data per index; unmapped reads as zero
   function automatic logic [7:0] rd_byte(
      input logic [wss_pkg::IDX_W-1:0] idx);
      if (idx == wss_pkg::IDX_AS0) begin
         rd_byte = as0_q;
      end else if (idx == wss_pkg::IDX_AS1) begin
         rd_byte = {1'b0, src_en_q};
      end else if (idx == wss_pkg::IDX_STR) begin
         rd_byte = str_q;
      end else if (idx == wss_pkg::IDX_CTRL) begin
         rd_byte = ctrl_q;
      end else if (idx == wss_pkg::IDX_POL) begin
         rd_byte = {2'h0, data_s, 1'b0, pol_q};
      end else if (idx == wss_pkg::IDX_DBR) begin
         rd_byte = {2'h0, dbr_q};
      end else if (idx == wss_pkg::IDX_DBF) begin
         rd_byte = {2'h0, dbf_q};
      end else if (idx == wss_pkg::IDX_IST) begin
         rd_byte = {6'h00, ist_q};
      end else if (idx == wss_pkg::IDX_IMSK) begin
         rd_byte = {6'h00, imsk_q};
      end else begin
         rd_byte = 8'h00;
      end
   endfunction : rd_byte

   // checks
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_flag_set: assert property (src_active |=> as0_q.shutdown)
      else $error("enabled source did not set shutdown flag");

   a_restart_clear: assert property (
      as0_q.restart_en && !src_active && !as0_wr |=> !as0_q.shutdown)
      else $error("auto restart did not clear shutdown flag");

   a_manual_keep: assert property (
      !as0_q.restart_en && as0_q.shutdown && !as0_wr |=> as0_q.shutdown)
      else $error("shutdown flag cleared without software");

   a_ac_high: assert property (
      hold_q && as0_q.pair_ac_shutdown_level == wss_pkg::LVL_HIGH
      |=> wave_out_a && wave_out_c && oe_q[0] && oe_q[2])
      else $error("a/c not driven high in shutdown");

   a_bd_tristate: assert property (
      hold_q && as0_q.pair_bd_shutdown_level == wss_pkg::LVL_HIZ
      |=> !oe_q[1] && !oe_q[3])
      else $error("b/d not released in shutdown");

   a_resume_edge: assert property (
      hold_q && !as0_q.shutdown && !data_rise |=> hold_q)
      else $error("outputs resumed without data rising edge");

   a_ac_deadband: assert property (
      hold_q && db_busy[0] && as0_q.pair_ac_shutdown_level ==
      wss_pkg::LVL_INACT |=> $stable(wave_out_a))
      else $error("a/c went inactive inside dead band");

   a_steer_data: assert property (
      !hold_q && en && steer_mode && steer_act_q[0]
      |=> wave_out_a == ($past(data_s) ^ $past(pol_q[0])))
      else $error("steered output does not follow data");

   a_override_lvl: assert property (
      !hold_q && en && steer_mode && !steer_act_q[1]
      |=> wave_out_b == $past(str_q[5]))
      else $error("override level not driven");

   a_sync_buffer: assert property (
      mode == wss_pkg::MODE_SYNC && !data_rise |=> $stable(steer_act_q))
      else $error("sync steering changed between data edges");

   a_db_length: assert property (
      (hold_d && !hold_q && dbf_q == 6'h04) |=> db_busy[0] [*4] ##1
      !db_busy[0])
      else $error("dead band length wrong");
endmodule : wave_shutdown_steering

// File: rtl/wss_pkg.sv
// Purpose: shared constants and types of the shutdown and steering stage
// Assumes: AXI4-Lite with 32-bit data, registers at byte address 4*index
// Notes:   register indices are word indices, not byte addresses
package wss_pkg;
   // bus geometry
   localparam int ADDR_W = 16;
   localparam int IDX_W = 14;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // register indices
   localparam logic [IDX_W-1:0] IDX_DBR = 14'h060E;
   localparam logic [IDX_W-1:0] IDX_DBF = 14'h060F;
   localparam logic [IDX_W-1:0] IDX_CTRL = 14'h0610;
   localparam logic [IDX_W-1:0] IDX_POL = 14'h0611;
   localparam logic [IDX_W-1:0] IDX_AS0 = 14'h0612;
   localparam logic [IDX_W-1:0] IDX_AS1 = 14'h0613;
   localparam logic [IDX_W-1:0] IDX_STR = 14'h0614;
   localparam logic [IDX_W-1:0] IDX_IST = 14'h0618;
   localparam logic [IDX_W-1:0] IDX_IMSK = 14'h0619;

   // field positions
   localparam int EN_BIT = 7;
   localparam int IN_BIT = 5;
   localparam int IRQ_ENTER = 0;
   localparam int IRQ_RESUME = 1;
   localparam int DB_W = 6;

   // reset values
   localparam logic [7:0] AS0_RST = 8'h14;
   localparam logic [6:0] AS1_RST = 7'h00;
   localparam logic [7:0] STR_RST = 8'h00;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] POL_RST = 4'h0;
   localparam logic [DB_W-1:0] DB_RST = 6'h00;

   // shutdown level codes and mode codes
   localparam logic [1:0] LVL_HIGH = 2'h3;
   localparam logic [1:0] LVL_LOW = 2'h2;
   localparam logic [1:0] LVL_HIZ = 2'h1;
   localparam logic [1:0] LVL_INACT = 2'h0;
   localparam logic [2:0] MODE_ASYNC = 3'h0;
   localparam logic [2:0] MODE_SYNC = 3'h1;

   // sources that shut down on a low level: logic cell, comparators, pin
   localparam logic [6:0] SRC_ACT_LOW = 7'h71;

   // shutdown control and status byte
   typedef struct packed {
      logic shutdown;
      logic restart_en;
      logic [1:0] pair_bd_shutdown_level;
      logic [1:0] pair_ac_shutdown_level;
      logic [1:0] unused;
   } sd_ctl_t;

   // shutdown source inputs, msb first
   typedef struct packed {
      logic logic_cell_result;
      logic comparator_two_result;
      logic comparator_one_result;
      logic timer_c_postscaled_tick;
      logic timer_b_postscaled_tick;
      logic timer_a_postscaled_tick;
      logic shutdown_pin_select;
   } sd_src_t;
endpackage : wss_pkg

// File: rtl/dead_band_timer.sv
// Purpose: dead-band interval timer for one output pair
// Assumes: start is a one-cycle pulse on aclk
// Notes:   busy stays high exactly count cycles; a zero count bypasses
`timescale 1ns/1ps
module dead_band_timer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic start,
   input wire logic [wss_pkg::DB_W-1:0] count,
   output logic busy
);
   logic [wss_pkg::DB_W-1:0] cnt_q;

   // load on start, count down while busy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= wss_pkg::DB_RST;
         busy <= 1'b0;
      end else if (start) begin
         cnt_q <= count;
         busy <= (count != wss_pkg::DB_RST);
      end else if (busy) begin
         cnt_q <= cnt_q - 6'h01;
         busy <= (cnt_q > 6'h01);
      end
   end
endmodule : dead_band_timer

// File: bench/bridge_driver_model.sv
// Purpose: gate driver inputs of the bridge stage fed by the four outputs
// Assumes: each driver input has a pull-down, so a released pin reads low
// Notes:   drv_on shows which pins the block actively drives
`timescale 1ns/1ps
module bridge_driver_model (
   // outputs of the block
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   // what the switch drivers see
   output logic [3:0] drv_level,
   output logic [3:0] drv_on
);
   // a released pin falls to the pull-down, it never keeps its last value
   assign drv_level = pin_out & pin_oe;
   assign drv_on = pin_oe;
endmodule : bridge_driver_model

// File: bench/tb_top.sv
// Purpose: self-checking bench of the shutdown and steering stage
// Assumes: registers at byte address 4*index, 40 MHz clock
// Notes:   steering cases run from a table, shutdown cases by hand
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic [7:0] ctrl;
      logic [3:0] pol;
      logic [7:0] str;
      logic dw;
      logic [3:0] exp;
   } row_t;
   localparam logic [6:0] IDLE = wss_pkg::SRC_ACT_LOW;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, irq, data_wave;
   logic wa, wb, wc, wd;
   logic [15:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, wave_oe, drv_level, drv_on;
   logic [1:0] bresp, rresp;
   logic [7:0] rv;
   wss_pkg::sd_src_t srcs;
   int error_cnt, num_checks, t0, t1;
   wire logic [7:0] pins = {drv_on, drv_level};
   // ordinary steering cases: control, polarity, steering, data, pins
   row_t rows [8] = '{'{8'h80, 4'h0, 8'h0F, 1'b1, 4'hF},
      '{8'h80, 4'h5, 8'h0F, 1'b1, 4'hA}, '{8'h80, 4'h5, 8'h0F, 1'b0, 4'h5},
      '{8'h80, 4'hF, 8'hA0, 1'b1, 4'hA}, '{8'h80, 4'h0, 8'h53, 1'b1, 4'h7},
      '{8'h82, 4'h3, 8'hF0, 1'b1, 4'h3}, '{8'h85, 4'h0, 8'hFF, 1'b1, 4'h0},
      '{8'h00, 4'h6, 8'h0F, 1'b1, 4'h6}};
   logic [13:0] rst_idx [5] = '{wss_pkg::IDX_AS0, wss_pkg::IDX_AS1,
      wss_pkg::IDX_STR, wss_pkg::IDX_CTRL, wss_pkg::IDX_IMSK};
   logic [7:0] rst_val [5] = '{8'h14, 8'h00, 8'h00, 8'h00, 8'h00};

   wave_shutdown_steering i_wave_shutdown_steering (
      .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid),
      .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp),
      .data_wave(data_wave), .shutdown_sources(srcs), .wave_out_a(wa),
      .wave_out_b(wb), .wave_out_c(wc), .wave_out_d(wd),
      .wave_oe(wave_oe), .irq(irq));
   bridge_driver_model i_bridge_driver_model (
      .pin_out({wd, wc, wb, wa}), .pin_oe(wave_oe),
      .drv_level(drv_level), .drv_on(drv_on));

   // 40 MHz clock
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   task automatic give_verdict;
      if (error_cnt == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // a wait that ran out ends the run at once
   task automatic tmo(input int n);
      if (n >= 64) begin
         error_cnt++;
         give_verdict();
      end
   endtask : tmo

   task automatic wr(input logic [13:0] idx, input logic [7:0] d,
                     input logic [1:0] er = wss_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= {idx, 2'h0};
      wvalid <= 1'b1;
      wdata <= {24'h0, d};
      bready <= 1'b1;
      // each channel is released at the edge that takes it
      do begin
         @(posedge aclk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 64);
      tmo(n);
      bready <= 1'b0;
      chk("bresp", {30'h0, bresp}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [13:0] idx, output logic [7:0] d,
                     input logic [1:0] er = wss_pkg::RESP_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {idx, 2'h0};
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 64);
      tmo(n);
      rready <= 1'b0;
      d = rdata[7:0];
      chk("rresp", {30'h0, rresp}, {30'h0, er});
   endtask : rd

   task automatic drive(input logic dw, input logic [6:0] s);
      @(posedge aclk);
      data_wave <= dw;
      srcs <= s;
   endtask : drive

   task automatic settle(input int k);
      repeat (k) @(posedge aclk);
      #1;
   endtask : settle

   // a fresh data rising edge lets held outputs resume
   task automatic restart;
      drive(1'b0, IDLE);
      settle(6);
      drive(1'b1, IDLE);
      settle(8);
   endtask : restart

   function automatic logic [1:0] lv(input logic [1:0] c, input logic p);
      case (c)
         2'h3: return 2'h3;
         2'h2: return 2'h2;
         2'h1: return 2'h0;
         default: return {1'b1, p};
      endcase
   endfunction : lv

   function automatic logic [7:0] sd_exp(input logic [1:0] ac, bd,
                                         input logic [3:0] p);
      logic [1:0] a, b, c, d;
      a = lv(ac, p[0]);
      b = lv(bd, p[1]);
      c = lv(ac, p[2]);
      d = lv(bd, p[3]);
      return {d[1], c[1], b[1], a[1], d[0], c[0], b[0], a[0]};
   endfunction : sd_exp

   // cycles from a pin shutdown until all outputs reach the low level
   task automatic db_time(input logic [5:0] n, output int t);
      wr(wss_pkg::IDX_DBR, {2'h0, n});
      wr(wss_pkg::IDX_DBF, {2'h0, n});
      t = 0;
      drive(1'b1, IDLE ^ 7'h01);
      do begin
         @(posedge aclk);
         #1;
         t++;
      end while (drv_level !== 4'h0 && t < 64);
      tmo(t);
      drive(1'b1, IDLE);
      settle(4);
      restart();
   endtask : db_time

   // main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      data_wave = 1'b0;
      srcs = IDLE;
      aresetn = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      settle(1);
      chk("pins after reset", pins, 8'hF0);
      foreach (rows[i]) begin
         wr(wss_pkg::IDX_CTRL, rows[i].ctrl);
         wr(wss_pkg::IDX_POL, {4'h0, rows[i].pol});
         wr(wss_pkg::IDX_STR, rows[i].str);
         drive(rows[i].dw, IDLE);
         settle(6);
         chk("steered pins", pins, {4'hF, rows[i].exp});
      end
      // second reset in mid-run, then reset values and unmapped places
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (rst_idx[i]) begin
         rd(rst_idx[i], rv);
         chk("reset value", rv, rst_val[i]);
      end
      rd(14'h0615, rv, wss_pkg::RESP_SLVERR);
      chk("unmapped read", rv, 8'h00);
      wr(14'h0615, 8'hFF, wss_pkg::RESP_SLVERR);
      // software shutdown while disabled, held until a data rising edge
      drive(1'b0, IDLE);
      wr(wss_pkg::IDX_AS0, 8'h94);
      settle(6);
      chk("forced shutdown pins", pins, 8'h00);
      rd(wss_pkg::IDX_AS0, rv);
      chk("forced flag", rv, 8'h94);
      wr(wss_pkg::IDX_AS0, 8'h14);
      settle(8);
      chk("held until edge", pins, 8'h00);
      drive(1'b1, IDLE);
      settle(8);
      chk("resumed inactive", pins, 8'hF0);
      // each source alone, first disabled, then enabled
      wr(wss_pkg::IDX_CTRL, 8'h80);
      wr(wss_pkg::IDX_STR, 8'h0F);
      wr(wss_pkg::IDX_AS0, 8'h78);
      for (int i = 0; i < 7; i++) begin
         wr(wss_pkg::IDX_AS1, 8'h00);
         drive(1'b1, IDLE ^ 7'(1 << i));
         settle(6);
         rd(wss_pkg::IDX_AS0, rv);
         chk("disabled source", rv, 8'h78);
         wr(wss_pkg::IDX_AS1, 8'(1 << i));
         settle(6);
         rd(wss_pkg::IDX_AS0, rv);
         chk("enabled source", rv, 8'hF8);
         chk("source pins", pins, 8'hFA);
         drive(1'b1, IDLE);
         settle(6);
         rd(wss_pkg::IDX_AS0, rv);
         chk("auto restart", rv, 8'h78);
         restart();
         chk("resumed", pins, 8'hFF);
      end
      // without auto-restart the flag waits for software
      wr(wss_pkg::IDX_AS0, 8'h38);
      wr(wss_pkg::IDX_AS1, 8'h01);
      drive(1'b1, IDLE ^ 7'h01);
      settle(6);
      drive(1'b1, IDLE);
      settle(6);
      rd(wss_pkg::IDX_AS0, rv);
      chk("flag held", rv, 8'hB8);
      wr(wss_pkg::IDX_AS0, 8'h38);
      settle(8);
      chk("held after clear", pins, 8'hFA);
      restart();
      chk("resumed latch", pins, 8'hFF);
      // every level code on both pairs
      wr(wss_pkg::IDX_POL, 8'h05);
      for (int c = 0; c < 4; c++) begin
         wr(wss_pkg::IDX_AS0, {2'h1, 2'(c ^ 1), 2'(c), 2'h0});
         drive(1'b1, IDLE ^ 7'h01);
         settle(8);
         chk("levels", pins, sd_exp(2'(c), 2'(c ^ 1), 4'h5));
         drive(1'b1, IDLE);
         settle(4);
         restart();
      end
      // dead band stretches the move to the inactive level
      wr(wss_pkg::IDX_POL, 8'h00);
      wr(wss_pkg::IDX_AS0, 8'h40);
      db_time(6'h00, t0);
      db_time(6'h04, t1);
      chk("dead band", {31'h0, (t1 - t0) inside {4, 5}}, 32'h1);
      wr(wss_pkg::IDX_DBR, 8'h00);
      wr(wss_pkg::IDX_DBF, 8'h00);
      // interrupt raised, cleared, then masked; stale events cleared first
      wr(wss_pkg::IDX_IST, 8'h03);
      wr(wss_pkg::IDX_IMSK, 8'h01);
      settle(3);
      chk("irq idle", {31'h0, irq}, 32'h0);
      drive(1'b1, IDLE ^ 7'h01);
      settle(8);
      chk("irq raised", {31'h0, irq}, 32'h1);
      drive(1'b1, IDLE);
      settle(6);
      wr(wss_pkg::IDX_IST, 8'h03);
      settle(3);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      restart();
      wr(wss_pkg::IDX_IMSK, 8'h00);
      drive(1'b1, IDLE ^ 7'h01);
      settle(8);
      chk("irq masked", {31'h0, irq}, 32'h0);
      rd(wss_pkg::IDX_IST, rv);
      chk("status sticky", {31'h0, rv[0]}, 32'h1);
      drive(1'b1, IDLE);
      settle(6);
      restart();
      // synchronous steering loads only at a data rising edge
      wr(wss_pkg::IDX_CTRL, 8'h81);
      wr(wss_pkg::IDX_POL, 8'h0F);
      wr(wss_pkg::IDX_STR, 8'h0F);
      restart();
      chk("sync steered", pins, 8'hF0);
      wr(wss_pkg::IDX_STR, 8'hF0);
      settle(8);
      chk("sync buffered", pins, 8'hF0);
      restart();
      chk("sync loaded", pins, 8'hFF);
      give_verdict();
   end
endmodule : tb_top
